// ===== src/flash_link_pkg.sv
package flash_link_pkg;
    localparam int          OPCODE_BITS     = 8;
    localparam int          BIT_CNT_W       = 4;
    localparam logic [7:0]  OP_READ         = 8'h03;
    localparam logic [7:0]  OP_DUAL_READ    = 8'h3b;
    localparam logic [7:0]  OP_BUSY_TRIGGER = 8'h02;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam int          HOST_DIV_HALF   = 4;
    localparam int          BUSY_CYCLES     = 16;
endpackage

// ===== src/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
    logic sel_n;
    logic sck;
    logic io0_host;
    logic io0_host_oe;
    logic io0_dev;
    logic io0_dev_oe;
    logic io1_dev;
    logic io1_dev_oe;
    logic hold_n;
    logic io0;
    logic io1;

    assign io0 = io0_dev_oe ? io0_dev : io0_host;
    assign io1 = io1_dev_oe ? io1_dev : 1'b0;

    modport device (
        input  sel_n,
        input  sck,
        input  io0,
        input  hold_n,
        output io0_dev,
        output io0_dev_oe,
        output io1_dev,
        output io1_dev_oe
    );
    modport host (
        output sel_n,
        output sck,
        output io0_host,
        output io0_host_oe,
        output hold_n,
        input  io1,
        input  io0
    );
endinterface

// ===== src/flash_link_device.sv
`timescale 1ns/1ps
// Summary of operation
// - falling select starts a new operation
// - rising select ends the current operation
// - stay active until self-timed cycle ends
// - deselect enters standby, never deep power-down
// - serial output floats while deselected
// - serial input ignored while deselected
// - input bits sampled on rising clock
// - output bits launched on falling clock
// - dual read drives two bits per fall
// - all commands and data enter on io0
// - clock may idle low or high
// - hold freezes clock, input, and output
// - hold starts with clock low, spares busy
module flash_link_device
    import flash_link_pkg::*;
(
    // system side
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic [7:0]  read_data,
    input  wire logic        busy_in,
    output logic [7:0]       rx_byte,
    output logic             rx_valid,
    output logic             dev_busy,
    output logic             dev_standby,
    output logic             dev_deep_pd,
    // link
    flash_link_if.device     link
);
    import flash_link_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD  = 4'b0010,
        ST_DATA = 4'b0100,
        ST_OUT  = 4'b1000
    } dev_state_t;

    // link-clock logic; select high acts as asynchronous clear of the frame
    logic                 active;
    logic                 hold_ok;
    dev_state_t           state;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [7:0]           shift_in;
    logic                 dual;
    logic [7:0]           tx_sh;
    logic                 out_en;
    logic                 rx_tog;
    logic [7:0]           rx_hold;

    // hold takes effect at once while selected, whatever the clock level
    assign hold_ok = ~link.hold_n & ~link.sel_n;
    assign active  = ~link.sel_n & ~hold_ok;

    always_ff @(posedge link.sck or posedge link.sel_n) begin
        if (link.sel_n) begin
            state    <= ST_IDLE;
            bit_cnt  <= '0;
            shift_in <= RESET_BYTE;
            dual     <= 1'b0;
        end else if (active) begin
            shift_in <= {shift_in[6:0], link.io0};
            unique case (state)
                ST_IDLE, ST_CMD: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    state   <= ST_CMD;
                    if (bit_cnt == 4'(OPCODE_BITS - 1)) begin
                        bit_cnt <= '0;
                        if ({shift_in[6:0], link.io0} == OP_DUAL_READ) begin
                            dual  <= 1'b1;
                            state <= ST_OUT;
                        end else if ({shift_in[6:0], link.io0} == OP_READ) begin
                            state <= ST_OUT;
                        end else begin
                            state <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    bit_cnt <= (bit_cnt == 4'(OPCODE_BITS - 1)) ? '0 : bit_cnt + 4'h1;
                end
                ST_OUT: begin
                    bit_cnt <= bit_cnt;
                end
            endcase
        end
    end

    // completed bytes cross via toggle; clock idle level is irrelevant
    always_ff @(posedge link.sck or posedge sys_rst) begin
        if (sys_rst) begin
            rx_tog  <= 1'b0;
            rx_hold <= 8'h00;
        end else if (active && bit_cnt == 4'(OPCODE_BITS - 1)) begin
            rx_tog  <= ~rx_tog;
            rx_hold <= {shift_in[6:0], link.io0};
        end
    end

    // output launched on the falling edge so the host samples on the next rise
    always_ff @(negedge link.sck or posedge link.sel_n) begin
        if (link.sel_n) begin
            tx_sh  <= 8'h00;
            out_en <= 1'b0;
        end else if (active && state == ST_OUT) begin
            out_en <= 1'b1;
            if (!out_en) begin
                tx_sh <= read_data;
            end else if (dual) begin
                tx_sh <= {tx_sh[5:0], tx_sh[7:6]};
            end else begin
                tx_sh <= {tx_sh[6:0], tx_sh[7]};
            end
        end
    end

    assign link.io1_dev    = dual ? tx_sh[7] : tx_sh[7];
    assign link.io0_dev    = tx_sh[6];
    assign link.io1_dev_oe = out_en & ~link.sel_n & ~hold_ok;
    assign link.io0_dev_oe = out_en & dual & ~link.sel_n & ~hold_ok;

    // system clock side
    logic [2:0] tog_sync;
    logic [1:0] sel_sync;
    logic [7:0] next_rx_byte;
    logic       next_rx_valid;
    logic       next_busy;
    logic       next_standby;

    always_comb begin
        next_rx_byte  = rx_byte;
        next_rx_valid = tog_sync[2] ^ tog_sync[1];
        if (next_rx_valid) begin
            next_rx_byte = rx_hold;
        end
        next_busy    = busy_in;
        // standby only once deselected and the self-timed cycle is over
        next_standby = sel_sync[1] & ~busy_in;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tog_sync    <= 3'h0;
            sel_sync    <= 2'h3;
            rx_byte     <= 8'h00;
            rx_valid    <= 1'b0;
            dev_busy    <= 1'b0;
            dev_standby <= 1'b1;
        end else if (ce) begin
            tog_sync    <= {tog_sync[1:0], rx_tog};
            sel_sync    <= {sel_sync[0], link.sel_n};
            rx_byte     <= next_rx_byte;
            rx_valid    <= next_rx_valid;
            dev_busy    <= next_busy;
            dev_standby <= next_standby;
        end
    end

    assign dev_deep_pd = 1'b0;
endmodule

// ===== src/flash_link_host.sv
`timescale 1ns/1ps
module flash_link_host
    import flash_link_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // request
    input  wire logic        start,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        last,
    input  wire logic        cpol,
    input  wire logic        dual_rx,
    input  wire logic        hold_req,
    output logic             ready,
    output logic [7:0]       rx_byte,
    output logic             rx_valid,
    // link
    flash_link_if.host       link
);
    import flash_link_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_XFER = 3'b010,
        H_END  = 3'b100
    } host_state_t;

    host_state_t state, next_state;
    logic [7:0] div, next_div;
    logic       sck_hi, next_sck_hi;
    logic [3:0] bits, next_bits;
    logic [7:0] tsh, next_tsh;
    logic [7:0] rsh, next_rsh;
    logic       lst, next_lst;
    logic [1:0] io1_s, io0_s;
    logic [7:0] next_rx_byte;
    logic       next_rx_valid;
    logic       tick;
    logic       first, next_first;
    logic       dual_now;
    logic       rise_edge;

    // the opcode byte always goes out on io0; dual receive only after it
    assign dual_now  = dual_rx & ~first;
    // edge that takes sck high: with cpol set that is when sck_hi drops
    assign rise_edge = (sck_hi == cpol);

    assign tick = (div == 8'(HOST_DIV_HALF - 1));

    always_comb begin
        next_state    = state;
        next_div      = tick ? 8'h00 : div + 8'h01;
        next_sck_hi   = sck_hi;
        next_bits     = bits;
        next_tsh      = tsh;
        next_rsh      = rsh;
        next_lst      = lst;
        next_first    = first;
        next_rx_byte  = rx_byte;
        next_rx_valid = 1'b0;
        unique case (state)
            H_IDLE: begin
                next_div = 8'h00;
                if (start) begin
                    next_state = H_XFER;
                    next_tsh   = tx_byte;
                    next_lst   = last;
                    next_bits  = 4'h0;
                    next_first = 1'b1;
                end
            end
            H_XFER: begin
                if (tick && !hold_req) begin
                    if (rise_edge) begin
                        next_sck_hi = ~sck_hi;
                        next_rsh    = dual_now ? {rsh[5:0], io1_s[1], io0_s[1]} : {rsh[6:0], io1_s[1]};
                        next_bits   = bits + (dual_now ? 4'h2 : 4'h1);
                    end else if (bits == 4'(OPCODE_BITS)) begin
                        next_rx_valid = 1'b1;
                        next_rx_byte  = rsh;
                        next_bits     = 4'h0;
                        next_tsh      = tx_byte;
                        next_first    = 1'b0;
                        next_lst      = last;
                        // mode 3 ends with the clock parked high after the last rise
                        if (!(lst && cpol)) begin
                            next_sck_hi = ~sck_hi;
                        end
                        if (lst) begin
                            next_state = H_END;
                        end
                    end else begin
                        next_sck_hi = ~sck_hi;
                        // mode 3 opens with a fall that precedes the first bit
                        if (bits != 4'h0) begin
                            next_tsh = {tsh[6:0], 1'b0};
                        end
                    end
                end
            end
            H_END: begin
                if (tick) begin
                    next_state = H_IDLE;
                end
            end
            default: next_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state    <= H_IDLE;
            div      <= 8'h00;
            sck_hi   <= 1'b0;
            bits     <= 4'h0;
            tsh      <= 8'h00;
            rsh      <= 8'h00;
            lst      <= 1'b0;
            first    <= 1'b0;
            io1_s    <= 2'h0;
            io0_s    <= 2'h0;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else if (ce) begin
            state    <= next_state;
            div      <= next_div;
            sck_hi   <= next_sck_hi;
            bits     <= next_bits;
            tsh      <= next_tsh;
            rsh      <= next_rsh;
            lst      <= next_lst;
            first    <= next_first;
            io1_s    <= {io1_s[0], link.io1};
            io0_s    <= {io0_s[0], link.io0};
            rx_byte  <= next_rx_byte;
            rx_valid <= next_rx_valid;
        end
    end

    assign ready            = (state == H_IDLE) |
                              (state == H_XFER && tick && !hold_req && !rise_edge && bits == 4'(OPCODE_BITS));
    assign link.sel_n       = (state == H_IDLE);
    assign link.sck         = cpol ^ sck_hi;
    assign link.io0_host    = tsh[7];
    assign link.io0_host_oe = (state != H_IDLE) & ~dual_now;
    assign link.hold_n      = ~(hold_req & rise_edge & (state != H_IDLE));
endmodule

// ===== verif/flash_link_checker.sv
`timescale 1ns/1ps
module flash_link_checker (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // link
    input wire logic sel_n,
    input wire logic sck,
    input wire logic io0_host,
    input wire logic io0_host_oe,
    input wire logic io0_dev,
    input wire logic io0_dev_oe,
    input wire logic io1_dev,
    input wire logic io1_dev_oe,
    input wire logic hold_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a few cycles of slack, though the enables drop with select itself, not via the synchroniser
    property p_desel_float; sel_n[*4] |-> !io1_dev_oe && !io0_dev_oe; endproperty
    a_desel_float: assert property (p_desel_float) else $error("output driven while deselected");
    property p_hold_float; !hold_n[*3] |-> !io1_dev_oe && !io0_dev_oe; endproperty
    a_hold_float: assert property (p_hold_float) else $error("output driven during hold");
    property p_hold_start; $fell(hold_n) |-> !sel_n && !sck; endproperty
    a_hold_start: assert property (p_hold_start) else $error("hold began outside low clock");
    property p_io1_launch; io1_dev_oe && $past(io1_dev_oe) && $changed(io1_dev) |-> !sck; endproperty
    a_io1_launch: assert property (p_io1_launch) else $error("io1 changed with clock high");
    property p_io0_launch; io0_dev_oe && $past(io0_dev_oe) && $changed(io0_dev) |-> !sck; endproperty
    a_io0_launch: assert property (p_io0_launch) else $error("io0 changed with clock high");
    property p_dual_pair; io0_dev_oe |-> io1_dev_oe; endproperty
    a_dual_pair: assert property (p_dual_pair) else $error("io0 driven without io1");
    property p_no_fight; io0_dev_oe |-> !io0_host_oe; endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive io0");
    property p_setup; !sel_n && $rose(sck) |-> $stable(io0_host); endproperty
    a_setup: assert property (p_setup) else $error("input bit moved at rising clock");
    property p_open; $fell(sel_n) |-> $stable(sck); endproperty
    a_open: assert property (p_open) else $error("clock moved as select fell");
    property p_close; $rose(sel_n) |-> $stable(sck); endproperty
    a_close: assert property (p_close) else $error("clock moved as select rose");
endmodule

// ===== verif/test_serial_flash_spi_front_end.sv
`timescale 1ns/1ps
module test_serial_flash_spi_front_end;
    import flash_link_pkg::*;
    logic       clk;
    logic       sys_rst;
    logic       start;
    logic [7:0] tx_byte;
    logic       last;
    logic       cpol;
    logic       dual_rx;
    logic       hold_req;
    logic       busy_in;
    logic [7:0] read_data;
    logic       ready;
    logic [7:0] h_byte;
    logic       h_valid;
    logic [7:0] d_byte;
    logic       d_valid;
    logic       dev_busy;
    logic       dev_standby;
    logic       dev_deep_pd;
    logic [7:0] h_q[$];
    logic [7:0] d_q[$];
    int         num_errors;
    int         check_count;

    flash_link_if link ();
    flash_link_host flash_link_host_i (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .start(start), .tx_byte(tx_byte),
        .last(last), .cpol(cpol), .dual_rx(dual_rx), .hold_req(hold_req), .ready(ready), .rx_byte(h_byte),
        .rx_valid(h_valid), .link(link));
    flash_link_device flash_link_device_i (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .read_data(read_data),
        .busy_in(busy_in), .rx_byte(d_byte), .rx_valid(d_valid), .dev_busy(dev_busy),
        .dev_standby(dev_standby), .dev_deep_pd(dev_deep_pd), .link(link));
    flash_link_checker flash_link_checker_i (.clk(clk), .sys_rst(sys_rst), .sel_n(link.sel_n), .sck(link.sck),
        .io0_host(link.io0_host), .io0_host_oe(link.io0_host_oe), .io0_dev(link.io0_dev),
        .io0_dev_oe(link.io0_dev_oe), .io1_dev(link.io1_dev), .io1_dev_oe(link.io1_dev_oe), .hold_n(link.hold_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (h_valid === 1'b1) h_q.push_back(h_byte);
        if (d_valid === 1'b1) d_q.push_back(d_byte);
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ready is looked at between edges and the request held through the edge that takes it
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) check("ready wait", 8'h00, 8'h01);
        @(posedge clk);
    endtask

    // one frame of two bytes; the host stalls mid opcode when hold is set
    task automatic xfer(input logic [7:0] op, input logic [7:0] b1, input logic pol, input logic dual,
                        input logic hold);
        int n;
        @(negedge clk);
        cpol = pol;
        dual_rx = dual;
        repeat (20) @(negedge clk);
        check("clock idle level", {7'h00, link.sck}, {7'h00, pol});
        h_q.delete();
        d_q.delete();
        start = 1'b1;
        tx_byte = op;
        last = 1'b0;
        wait_ready();
        @(negedge clk);
        start = 1'b0;
        tx_byte = b1;
        last = 1'b1;
        if (hold) begin
            repeat (16) @(negedge clk);
            hold_req = 1'b1;
            repeat (40) @(negedge clk);
            check("bytes during hold", d_q.size(), 8'h00);
            hold_req = 1'b0;
        end
        wait_ready();
        n = 0;
        while (link.sel_n !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        check("opcode at device", d_q[0], op);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 2; m++) begin
            read_data = 8'h5a ^ m[7:0];
            xfer(OP_READ, 8'h00, m[0], 1'b0, 1'b0);
            check("read byte", h_q[1], read_data);
        end
    endtask

    task automatic t_dual();
        read_data = 8'hc3;
        xfer(OP_DUAL_READ, 8'h00, 1'b0, 1'b1, 1'b0);
        check("dual read byte", h_q[1], read_data);
    endtask

    task automatic t_hold();
        xfer(8'ha6, 8'h5c, 1'b0, 1'b0, 1'b1);
        check("byte after hold", d_q[1], 8'h5c);
    endtask

    task automatic t_busy();
        int n;
        busy_in = 1'b1;
        xfer(OP_BUSY_TRIGGER, 8'h11, 1'b0, 1'b0, 1'b0);
        check("standby while busy", {7'h00, dev_standby}, 8'h00);
        check("busy flag", {7'h00, dev_busy}, 8'h01);
        @(negedge clk);
        busy_in = 1'b0;
        n = 0;
        while (dev_standby !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check("standby after busy", {7'h00, dev_standby}, 8'h01);
        check("deep power-down", {7'h00, dev_deep_pd}, 8'h00);
        d_q.delete();
        repeat (100) @(posedge clk);
        check("bytes while idle", d_q.size(), 8'h00);
    endtask

    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end

    initial begin
        num_errors = 0;
        check_count = 0;
        sys_rst = 1'b1;
        start = 1'b0;
        tx_byte = 8'h00;
        last = 1'b0;
        cpol = 1'b0;
        dual_rx = 1'b0;
        hold_req = 1'b0;
        busy_in = 1'b0;
        read_data = 8'h00;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        t_modes();
        t_dual();
        t_hold();
        t_busy();
        end_of_test();
    end
endmodule
